// ### itc_pkg.sv
// Constants, register map and field layout of the timing and
// bus configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package itc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_MUX_SEL  = 12'h410;
  localparam logic [11:0] IDX_MUX_DATA = 12'h411;
  localparam logic [11:0] IDX_PERSIST  = 12'h412;
  localparam logic [11:0] IDX_BUS_CTL  = 12'h413;
  localparam int          ADDR_W       = 14;

  // Reset values.
  localparam logic [7:0] RST_MUX_SEL = 8'h00;
  localparam logic [7:0] RST_PERSIST = 8'h00;
  localparam logic [7:0] RST_BUS_CTL = 8'h00;
  localparam logic [5:0] RST_SRC     = 6'h00;
  localparam logic [3:0] RST_DIV     = 4'h0;

  // Selector fields.
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 6;
  localparam int SEL_ID_MSB   = 3;

  // Data fields.
  localparam int SRC_MSB = 5;
  localparam int DIV_MSB = 3;

  // Persistence fields.
  localparam int ALPHA_BIT  = 6;
  localparam int BETA_MSB   = 5;
  localparam int BETA_LSB   = 3;
  localparam int GAMMA_MSB  = 2;
  localparam logic [2:0] PERSIST_MAX = 3'h4;

  // Bus control bits.
  localparam int BC_ADDR_MODE  = 6;
  localparam int BC_RX_TRI_DIS = 5;
  localparam int BC_RX_CLAV_MD = 4;
  localparam int BC_TX_LAST4   = 3;
  localparam int BC_TX_CLAV_MD = 2;
  localparam int BC_CLAV_TRI   = 1;
  localparam int BC_SAMPLE_T   = 0;

  // Timing source codes.
  localparam logic [5:0] SRC_PORT_MAX = 6'h1F;
  localparam logic [5:0] SRC_SYSCLK   = 6'h20;
  localparam logic [5:0] SRC_REFCLK   = 6'h21;
  localparam logic [5:0] SRC_FIXED_8K = 6'h22;

  // Divisor codes.
  localparam logic [3:0] DIV_LINK_TYPE = 4'h0;
  localparam logic [3:0] DIV_1_1       = 4'h1;
  localparam logic [3:0] DIV_192_193   = 4'h2;
  localparam logic [3:0] DIV_15_16     = 4'h3;

  // Payload byte periods that must pass before the delayed sample.
  localparam logic [2:0] SAMPLE_DELAY_BYTES = 3'h5;
  localparam int         NUM_TRL            = 2;

  typedef enum logic [1:0] {
    SEL_RX_GROUP, SEL_TX_GROUP, SEL_TRL_OUT, SEL_CLK_DIV
  } itc_sel_type_t;

  typedef enum logic [2:0] {
    KIND_PORT, KIND_SYSCLK, KIND_REFCLK, KIND_FIXED_8K, KIND_NONE
  } itc_src_kind_t;

  typedef enum logic [1:0] {
    RATIO_LINK_TYPE, RATIO_1_1, RATIO_192_193, RATIO_15_16
  } itc_ratio_t;

endpackage : itc_pkg

`default_nettype wire

// ### itc_cfg_if.sv
// Bus control settings passed from the register bank to the
// ATM-side port control.
// Assumes both ends run on the same clock.
`default_nettype none

interface itc_cfg_if;
  logic addr_mode;
  logic rx_tri_dis;
  logic rx_clav_mode;
  logic tx_last4_mode;
  logic tx_clav_mode;
  logic clav_tri_dis;
  logic sample_time;

  modport bank (output addr_mode, rx_tri_dis, rx_clav_mode, tx_last4_mode,
                tx_clav_mode, clav_tri_dis, sample_time);
  modport port (input  addr_mode, rx_tri_dis, rx_clav_mode, tx_last4_mode,
                tx_clav_mode, clav_tri_dis, sample_time);
endinterface : itc_cfg_if

`default_nettype wire

// ### itc_utopia_ctl.sv
// ATM-side port control: output enables and cell-available values.
// Assumes transfer and selection indications from the cell datapath.
`default_nettype none

module itc_utopia_ctl
  import itc_pkg::*;
(
  itc_cfg_if.port   cfg,
  input  wire logic addr_match_i,
  input  wire logic rx_xfer_i,
  input  wire logic tx_xfer_i,
  input  wire logic tx_last4_i,
  input  wire logic rx_clav_status_i,
  input  wire logic tx_clav_status_i,
  output logic      rx_bus_oe_o,
  output logic      atm_rx_cell_available_o,
  output logic      atm_tx_cell_available_o,
  output logic      clav_oe_o
);

  logic selected;

  // Single-address mode has no address latching, so the port counts as
  // selected at all times; otherwise the latched address decides.
  assign selected = cfg.addr_mode | addr_match_i;

  // Outputs float while unselected unless three-stating is disabled.
  assign rx_bus_oe_o = selected | cfg.rx_tri_dis;
  assign clav_oe_o   = selected | cfg.clav_tri_dis;

  // Cell-available values are forced during a transfer, except transmit in the last four beats when tx_last4_mode is set.
  always_comb begin
    atm_rx_cell_available_o = rx_clav_status_i;
    if (rx_xfer_i) begin
      atm_rx_cell_available_o = ~cfg.rx_clav_mode;
    end
    atm_tx_cell_available_o = tx_clav_status_i;
    if (tx_xfer_i && !(tx_last4_i && cfg.tx_last4_mode)) begin
      atm_tx_cell_available_o = cfg.tx_clav_mode;
    end
  end

endmodule // itc_utopia_ctl

`default_nettype wire

// ### itc_top.sv
// Timing reference and ATM-side bus configuration registers behind an
// Avalon-MM slave with waitrequest.
// Assumes the cell datapath supplies transfer and byte-period indications
// and resolves the three-state pins from the enables given here.
//
// Function
// - Timing elements are programmed indirectly: select first, then write data.
// - Selector type picks rx group, tx group, reference output or divisor.
// - For types 0, 1 and 3 the identifier names group 0 to 15.
// - For type 2 identifier 0 or 1 picks the reference output.
// - Group source: ports 0-31, divided clock or generator, reference clock.
// - Output source: port, clock divided by 24, reference clock, or 8 kHz.
// - Divisor codes: link-type derived, 1/1, 192/193, 15/16.
// - Alpha bit sets one or two invalid control cells to leave sync.
// - Beta 0-4 sets one to five errored control cells to leave sync.
// - Gamma 0-4 sets one to five valid control cells to enter sync.
// - Address mode chooses multi-address or single fixed-address operation.
// - Receive data, start and parity float when unselected unless disabled.
// - Receive cell-available forced active or inactive during transfer.
// - Transmit cell-available forced inactive or active during transfer.
// - Last four beats show forced or true transmit cell-available.
// - Both cell-available outputs float when unselected unless disabled.
// - PHY cell-available sampled in control cell or over five bytes later.
`default_nettype none

module itc_top
  import itc_pkg::*;
#(
  parameter int NUM_GROUPS = 16
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic [ADDR_W-1:0]       avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  output logic      [NUM_GROUPS*6-1:0] rx_group_src_o,
  output logic      [NUM_GROUPS*3-1:0] rx_group_kind_o,
  output logic      [NUM_GROUPS*6-1:0] tx_group_src_o,
  output logic      [NUM_GROUPS*3-1:0] tx_group_kind_o,
  output logic      [NUM_TRL*6-1:0]    timing_ref_output_src_o,
  output logic      [NUM_TRL*3-1:0]    timing_ref_output_kind_o,
  output logic      [NUM_GROUPS*2-1:0] group_ratio_o,
  output logic      [1:0]              alpha_cells_o,
  output logic      [2:0]              beta_cells_o,
  output logic      [2:0]              gamma_cells_o,
  output logic                         atm_level1_mode_o,
  input  wire logic                    atm_addr_match_i,
  input  wire logic                    atm_rx_xfer_i,
  input  wire logic                    atm_tx_xfer_i,
  input  wire logic                    atm_tx_last4_i,
  input  wire logic                    rx_clav_status_i,
  input  wire logic                    tx_clav_status_i,
  input  wire logic                    ctl_cell_xfer_i,
  input  wire logic                    byte_tick_i,
  input  wire logic                    phy_tx_cell_available_i,
  output logic                         atm_rx_bus_oe_o,
  output logic                         atm_rx_cell_available_o,
  output logic                         atm_tx_cell_available_o,
  output logic                         atm_clav_oe_o,
  output logic                         phy_clav_sample_o,
  output logic                         phy_clav_strobe_o
);

  localparam logic [ADDR_W-1:0] ADR_MUX_SEL  = {IDX_MUX_SEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MUX_DATA = {IDX_MUX_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PERSIST  = {IDX_PERSIST, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_BUS_CTL  = {IDX_BUS_CTL, 2'b00};

  // Register state.
  logic [7:0] mux_sel;
  logic [7:0] persist;
  logic [6:0] bus_ctl;
  logic [5:0] rx_src  [NUM_GROUPS];
  logic [5:0] tx_src  [NUM_GROUPS];
  logic [5:0] trl_src [NUM_TRL];
  logic [3:0] clk_div [NUM_GROUPS];

  // Bus handshake state and decode.
  logic          ack;
  logic          req;
  logic          wr_take;
  logic          lane0;
  logic [7:0]    wbyte;
  logic [7:0]    next_rdata;
  itc_sel_type_t sel_type;
  logic [3:0]    sel_id;
  logic          grp_ok;
  logic          trl_ok;
  logic          data_wr;

  itc_cfg_if cfg_bus ();

  // Every access waits one cycle; the second cycle carries the answer so
  // read data comes straight from a flip-flop.
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_take           = avs_write_i & ack;
  assign lane0             = avs_byteenable_i[0];
  assign wbyte             = avs_writedata_i[7:0];

  // Selector decoding drives where a data write lands.
  assign sel_type = itc_sel_type_t'(mux_sel[SEL_TYPE_MSB:SEL_TYPE_LSB]);
  assign sel_id   = mux_sel[SEL_ID_MSB:0];
  assign grp_ok   = 32'(sel_id) < NUM_GROUPS;
  assign trl_ok   = 32'(sel_id) < NUM_TRL;
  assign data_wr  = wr_take && lane0 && (avs_address_i == ADR_MUX_DATA);

  // Acknowledge pulses once per request.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Direct registers; writes ignore the upper byte lanes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mux_sel <= RST_MUX_SEL;
      persist <= RST_PERSIST;
      bus_ctl <= RST_BUS_CTL[6:0];
    end else if (wr_take && lane0) begin
      if (avs_address_i == ADR_MUX_SEL) begin
        // Reserved bits 5 and 4 are kept at zero.
        mux_sel <= {wbyte[7:6], 2'b00, wbyte[3:0]};
      end else if (avs_address_i == ADR_PERSIST) begin
        persist <= {1'b0, wbyte[6:0]};
      end else if (avs_address_i == ADR_BUS_CTL) begin
        bus_ctl <= wbyte[6:0];
      end
    end
  end

  // Indirect timing elements, one storage slot per group and output.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_GROUPS; i++) begin
        rx_src[i]  <= RST_SRC;
        tx_src[i]  <= RST_SRC;
        clk_div[i] <= RST_DIV;
      end
      for (int i = 0; i < NUM_TRL; i++) begin
        trl_src[i] <= RST_SRC;
      end
    end else if (data_wr) begin
      // Only the element the selector names is touched.
      case (sel_type)
        SEL_RX_GROUP: begin
          if (grp_ok) rx_src[sel_id] <= wbyte[SRC_MSB:0];
        end
        SEL_TX_GROUP: begin
          if (grp_ok) tx_src[sel_id] <= wbyte[SRC_MSB:0];
        end
        SEL_TRL_OUT: begin
          if (trl_ok) trl_src[sel_id[0]] <= wbyte[SRC_MSB:0];
        end
        SEL_CLK_DIV: begin
          if (grp_ok) clk_div[sel_id] <= wbyte[DIV_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; the data register reads back the selected element.
  always_comb begin
    next_rdata = 8'h00;
    if (avs_address_i == ADR_MUX_SEL) begin
      next_rdata = mux_sel;
    end else if (avs_address_i == ADR_MUX_DATA) begin
      case (sel_type)
        SEL_RX_GROUP: begin
          if (grp_ok) next_rdata = {2'b00, rx_src[sel_id]};
        end
        SEL_TX_GROUP: begin
          if (grp_ok) next_rdata = {2'b00, tx_src[sel_id]};
        end
        SEL_TRL_OUT: begin
          if (trl_ok) next_rdata = {2'b00, trl_src[sel_id[0]]};
        end
        SEL_CLK_DIV: begin
          if (grp_ok) next_rdata = {4'h0, clk_div[sel_id]};
        end
        default: begin
        end
      endcase
    end else if (avs_address_i == ADR_PERSIST) begin
      next_rdata = persist;
    end else if (avs_address_i == ADR_BUS_CTL) begin
      next_rdata = {1'b0, bus_ctl};
    end
  end

  // Read data is captured on the waiting cycle and held until the next
  // read, which keeps it stable at the completing edge.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= {24'h00_0000, next_rdata};
    end
  end

  // Source decode for group references; a code past the reference clock
  // is not defined for groups and reports no source.
  function automatic logic [2:0] grp_kind(input logic [5:0] src);
    itc_src_kind_t k;
    k = KIND_NONE;
    if (src <= SRC_PORT_MAX) k = KIND_PORT;
    else if (src == SRC_SYSCLK) k = KIND_SYSCLK;
    else if (src == SRC_REFCLK) k = KIND_REFCLK;
    return k;
  endfunction

  // Output sources additionally allow the fixed 8 kHz reference.
  function automatic logic [2:0] trl_kind(input logic [5:0] src);
    itc_src_kind_t k;
    k = itc_src_kind_t'(grp_kind(src));
    if (src == SRC_FIXED_8K) k = KIND_FIXED_8K;
    return k;
  endfunction

  // Divisor decode; unused codes fall back to the link-type default.
  function automatic logic [1:0] div_ratio(input logic [3:0] d);
    itc_ratio_t r;
    r = RATIO_LINK_TYPE;
    if (d == DIV_1_1) r = RATIO_1_1;
    else if (d == DIV_192_193) r = RATIO_192_193;
    else if (d == DIV_15_16) r = RATIO_15_16;
    return r;
  endfunction

  // Per-group configuration fanned out to the timing logic.
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    assign rx_group_src_o[g*6 +: 6]  = rx_src[g];
    assign tx_group_src_o[g*6 +: 6]  = tx_src[g];
    assign rx_group_kind_o[g*3 +: 3] = grp_kind(rx_src[g]);
    assign tx_group_kind_o[g*3 +: 3] = grp_kind(tx_src[g]);
    assign group_ratio_o[g*2 +: 2]   = div_ratio(clk_div[g]);
  end

  // Reference output configuration.
  for (genvar t = 0; t < NUM_TRL; t++) begin : g_trl
    assign timing_ref_output_src_o[t*6 +: 6]  = trl_src[t];
    assign timing_ref_output_kind_o[t*3 +: 3] = trl_kind(trl_src[t]);
  end

  // Persistence counts; out-of-range beta and gamma codes saturate at
  // five cells rather than wrapping to a short count.
  always_comb begin
    alpha_cells_o = persist[ALPHA_BIT] ? 2'd2 : 2'd1;
    beta_cells_o  = 3'd5;
    gamma_cells_o = 3'd5;
    if (persist[BETA_MSB:BETA_LSB] <= PERSIST_MAX) begin
      beta_cells_o = persist[BETA_MSB:BETA_LSB] + 3'd1;
    end
    if (persist[GAMMA_MSB:0] <= PERSIST_MAX) begin
      gamma_cells_o = persist[GAMMA_MSB:0] + 3'd1;
    end
  end

  // Bus control bits handed to the port logic.
  assign cfg_bus.addr_mode     = bus_ctl[BC_ADDR_MODE];
  assign cfg_bus.rx_tri_dis    = bus_ctl[BC_RX_TRI_DIS];
  assign cfg_bus.rx_clav_mode  = bus_ctl[BC_RX_CLAV_MD];
  assign cfg_bus.tx_last4_mode = bus_ctl[BC_TX_LAST4];
  assign cfg_bus.tx_clav_mode  = bus_ctl[BC_TX_CLAV_MD];
  assign cfg_bus.clav_tri_dis  = bus_ctl[BC_CLAV_TRI];
  assign cfg_bus.sample_time   = bus_ctl[BC_SAMPLE_T];
  assign atm_level1_mode_o     = bus_ctl[BC_ADDR_MODE];

  // Sampling state for the PHY-side transmit cell-available input.
  logic       ctl_prev;
  logic       ctl_seen;
  logic       armed;
  logic [2:0] tick_cnt;
  logic       take;

  // Immediate mode samples at the first byte period of a control cell;
  // delayed mode counts byte periods after the cell and samples on the
  // one that follows the fifth.
  always_comb begin
    if (!cfg_bus.sample_time) begin
      take = ctl_cell_xfer_i & byte_tick_i & ~ctl_seen;
    end else begin
      take = armed & byte_tick_i & (tick_cnt == SAMPLE_DELAY_BYTES);
    end
  end

  // Tracks the control cell and the delay after it.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctl_prev <= 1'b0;
      ctl_seen <= 1'b0;
      armed    <= 1'b0;
      tick_cnt <= 3'h0;
    end else begin
      ctl_prev <= ctl_cell_xfer_i;
      ctl_seen <= ctl_cell_xfer_i & (ctl_seen | byte_tick_i);
      if (ctl_prev && !ctl_cell_xfer_i) begin
        armed    <= 1'b1;
        tick_cnt <= 3'h0;
      end else if (take) begin
        armed <= 1'b0;
      end else if (armed && byte_tick_i) begin
        tick_cnt <= tick_cnt + 3'h1;
      end
    end
  end

  // Holds the sampled value used for the stuffing rate.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phy_clav_sample_o <= 1'b0;
      phy_clav_strobe_o <= 1'b0;
    end else begin
      phy_clav_strobe_o <= take;
      if (take) begin
        phy_clav_sample_o <= phy_tx_cell_available_i;
      end
    end
  end

  // ATM-side port control.
  itc_utopia_ctl u_port (
    .cfg                     (cfg_bus),
    .addr_match_i            (atm_addr_match_i),
    .rx_xfer_i               (atm_rx_xfer_i),
    .tx_xfer_i               (atm_tx_xfer_i),
    .tx_last4_i              (atm_tx_last4_i),
    .rx_clav_status_i        (rx_clav_status_i),
    .tx_clav_status_i        (tx_clav_status_i),
    .rx_bus_oe_o             (atm_rx_bus_oe_o),
    .atm_rx_cell_available_o (atm_rx_cell_available_o),
    .atm_tx_cell_available_o (atm_tx_cell_available_o),
    .clav_oe_o               (atm_clav_oe_o)
  );

endmodule // itc_top

`default_nettype wire

// ### itc_monitor.sv
// Concurrent checks on the ports of the timing and bus control bank.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module itc_monitor
  import itc_pkg::*;
#(
  parameter int NUM_GROUPS = 16
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic [2:0] beta_cells_o,
  input wire logic [2:0] gamma_cells_o,
  input wire logic       atm_level1_mode_o,
  input wire logic       atm_addr_match_i,
  input wire logic       atm_rx_xfer_i,
  input wire logic       atm_tx_xfer_i,
  input wire logic       rx_clav_status_i,
  input wire logic       tx_clav_status_i,
  input wire logic       byte_tick_i,
  input wire logic       atm_rx_bus_oe_o,
  input wire logic       atm_rx_cell_available_o,
  input wire logic       atm_tx_cell_available_o,
  input wire logic       atm_clav_oe_o,
  input wire logic       phy_clav_strobe_o
);
  // Every check runs on the core clock and rests while reset is high.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // A pending request is answered after exactly one wait cycle.
  wait_one_a: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");

  // A selected port drives its pins; single-address mode always selects.
  lvl1_sel_a: assert property (atm_level1_mode_o
    |-> atm_rx_bus_oe_o && atm_clav_oe_o) else $error("level1 not driving");
  rx_oe_a: assert property (atm_addr_match_i |-> atm_rx_bus_oe_o)
    else $error("rx bus floats while selected");
  clav_oe_a: assert property (atm_addr_match_i |-> atm_clav_oe_o)
    else $error("cell available floats while selected");

  // Persistence counts stay within one to five cells.
  beta_rng_a: assert property (beta_cells_o inside {[3'd1:3'd5]})
    else $error("beta count out of range");
  gamma_rng_a: assert property (gamma_cells_o inside {[3'd1:3'd5]})
    else $error("gamma count out of range");

  // A sample strobe follows a byte period one or two cycles earlier.
  strobe_tick_a: assert property (phy_clav_strobe_o
    |-> $past(byte_tick_i) || $past(byte_tick_i, 2))
    else $error("strobe without byte period");

  // Outside a transfer the true cell-available status is shown.
  rx_cav_a: assert property (!atm_rx_xfer_i
    |-> atm_rx_cell_available_o == rx_clav_status_i)
    else $error("rx cell available wrong when idle");
  tx_cav_a: assert property (!atm_tx_xfer_i
    |-> atm_tx_cell_available_o == tx_clav_status_i)
    else $error("tx cell available wrong when idle");
endmodule // itc_monitor

bind itc_top itc_monitor #(.NUM_GROUPS(NUM_GROUPS)) itc_monitor_inst (
  .clk_sys_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .beta_cells_o, .gamma_cells_o, .atm_level1_mode_o, .atm_addr_match_i,
  .atm_rx_xfer_i, .atm_tx_xfer_i, .rx_clav_status_i, .tx_clav_status_i,
  .byte_tick_i, .atm_rx_bus_oe_o, .atm_rx_cell_available_o,
  .atm_tx_cell_available_o, .atm_clav_oe_o, .phy_clav_strobe_o);

`default_nettype wire

// ### itc_atm_model.sv
// Behavioural ATM-layer side: selection, transfers and byte periods.
// Assumes the bench calls its tasks; every change lands on a rising edge.
`default_nettype none

module itc_atm_model (
  input  wire logic       clk_sys_i,
  output var  logic [8:0] ind_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at start: nothing selected, no transfer, no byte period.
  initial ind_o = 9'h000;

  // Order: select, rx xfer, tx xfer, last four, rx and tx status,
  // control cell, byte period, PHY cell available.
  task automatic set(input logic [8:0] v);
    @(posedge clk_sys_i);
    ind_o <= v;
  endtask

  // A byte period is one cycle wide, so a slow tick cannot double count.
  task automatic tick();
    @(posedge clk_sys_i);
    ind_o[1] <= 1'b1;
    @(posedge clk_sys_i);
    ind_o[1] <= 1'b0;
  endtask
endmodule // itc_atm_model

`default_nettype wire

// ### tb_itc_top.sv
// Self-checking bench for the timing and bus control bank.
// Assumes the monitor is bound in and the model drives the port inputs.
`default_nettype none

module tb_itc_top
  import itc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i        = 1'b0;
  logic        rst_i            = 1'b1;
  logic [13:0] avs_address_i    = 14'h0000;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [95:0] rxs, txs;
  logic [47:0] rxk, txk;
  logic [11:0] trs;
  logic [5:0]  trk;
  logic [31:0] ratio;
  logic [1:0]  alpha;
  logic [2:0]  beta, gamma, k;
  logic        lvl1, rx_oe, rx_cav, tx_cav, clav_oe, smp, stb;
  logic [8:0]  ind;
  logic [3:0]  be_v = 4'h1;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [31:0] s;
  logic [7:0]  bc_tab [9] = '{8'h02, 8'h40, 8'h20, 8'h00, 8'h00,
                              8'h14, 8'h04, 8'h0C, 8'h0C};
  logic [8:0]  in_tab [9] = '{9'h000, 9'h000, 9'h000, 9'h100, 9'h1C0,
                              9'h1D8, 9'h1E0, 9'h1E0, 9'h1C0};
  logic [4:0]  ex_tab [9] = '{5'h08, 5'h19, 5'h10, 5'h18, 5'h1C,
                              5'h1A, 5'h1E, 5'h1C, 5'h1E};

  itc_top #(.NUM_GROUPS(16)) itc_top_inst (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .rx_group_src_o(rxs), .rx_group_kind_o(rxk),
    .tx_group_src_o(txs), .tx_group_kind_o(txk),
    .timing_ref_output_src_o(trs), .timing_ref_output_kind_o(trk),
    .group_ratio_o(ratio), .alpha_cells_o(alpha), .beta_cells_o(beta),
    .gamma_cells_o(gamma), .atm_level1_mode_o(lvl1),
    .atm_addr_match_i(ind[8]), .atm_rx_xfer_i(ind[7]),
    .atm_tx_xfer_i(ind[6]), .atm_tx_last4_i(ind[5]),
    .rx_clav_status_i(ind[4]), .tx_clav_status_i(ind[3]),
    .ctl_cell_xfer_i(ind[2]), .byte_tick_i(ind[1]),
    .phy_tx_cell_available_i(ind[0]), .atm_rx_bus_oe_o(rx_oe),
    .atm_rx_cell_available_o(rx_cav), .atm_tx_cell_available_o(tx_cav),
    .atm_clav_oe_o(clav_oe), .phy_clav_sample_o(smp),
    .phy_clav_strobe_o(stb));

  itc_atm_model model_inst (.clk_sys_i(clk_sys_i), .ind_o(ind));

  // Free-running 100 MHz core clock.
  always #5 clk_sys_i = ~clk_sys_i;

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon access held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [11:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    avs_address_i    <= {idx, 2'b00};
    avs_writedata_i  <= {24'h00_0000, d};
    avs_byteenable_i <= be_v;
    avs_write_i      <= w;
    avs_read_i       <= !w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h00_0000, e}, $sformatf("register %h", idx));
  endtask

  // One byte period, then count strobes over the following cycles.
  task automatic tk(output logic [31:0] n);
    model_inst.tick();
    #1;
    n = 32'(stb);
    repeat (3) begin
      @(posedge clk_sys_i);
      #1;
      n += 32'(stb);
    end
  endtask

  task automatic done(input string n);
    $display("Test %s finished", n);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset values, persistence, indirect pair, port control, sample time.
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdc(IDX_MUX_SEL, RST_MUX_SEL);
    rdc(IDX_MUX_DATA, {2'b00, RST_SRC});
    rdc(IDX_BUS_CTL, RST_BUS_CTL);
    be_v = 4'h0;
    wr(IDX_PERSIST, 8'h7F);
    be_v = 4'h1;
    rdc(IDX_PERSIST, RST_PERSIST);
    wr(12'h414, 8'h5A);
    rdc(12'h414, 8'h00);
    done("reset");
    for (int i = 0; i < 5; i++) begin
      k = i[2:0];
      wr(IDX_PERSIST, {1'b0, k[0], k, k});
      rdc(IDX_PERSIST, {1'b0, k[0], k, k});
      chk(alpha, k[0] + 2'd1, "alpha");
      chk(beta, k + 3'd1, "beta");
      chk(gamma, k + 3'd1, "gamma");
    end
    done("persistence");
    wr(IDX_MUX_SEL, 8'h05);
    wr(IDX_MUX_DATA, 8'h21);
    chk(rxs[35:30], SRC_REFCLK, "rx source");
    chk(rxk[17:15], KIND_REFCLK, "rx kind");
    chk(txs[35:30], 6'h00, "tx untouched");
    wr(IDX_MUX_SEL, 8'h45);
    wr(IDX_MUX_DATA, 8'h20);
    chk(txs[35:30], SRC_SYSCLK, "tx source");
    chk(txk[17:15], KIND_SYSCLK, "tx kind");
    chk(rxs[35:30], SRC_REFCLK, "rx kept");
    wr(IDX_MUX_SEL, 8'h81);
    wr(IDX_MUX_DATA, 8'h22);
    chk(trs[11:6], SRC_FIXED_8K, "ref out source");
    chk(trk[5:3], KIND_FIXED_8K, "ref out kind");
    chk(trs[5:0], 6'h00, "ref out zero");
    wr(IDX_MUX_SEL, 8'h0F);
    wr(IDX_MUX_DATA, 8'h1F);
    rdc(IDX_MUX_DATA, 8'h1F);
    chk(rxk[47:45], KIND_PORT, "rx kind last group");
    wr(IDX_MUX_SEL, 8'hC5);
    rdc(IDX_MUX_SEL, 8'hC5);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_MUX_DATA, i[7:0]);
      chk(ratio[11:10], i[1:0], "ratio");
    end
    chk(ratio[9:8], 2'd0, "ratio untouched");
    done("indirect");
    for (int i = 0; i < 9; i++) begin
      wr(IDX_BUS_CTL, bc_tab[i]);
      rdc(IDX_BUS_CTL, bc_tab[i]);
      model_inst.set(in_tab[i]);
      #1;
      chk({rx_oe, clav_oe, rx_cav, tx_cav, lvl1}, ex_tab[i], "port");
    end
    done("port control");
    wr(IDX_BUS_CTL, 8'h00);
    model_inst.set(9'h005);
    tk(s);
    chk(s, 1, "first tick strobe");
    chk(smp, 1'b1, "sampled value");
    tk(s);
    chk(s, 0, "second tick strobe");
    wr(IDX_BUS_CTL, 8'h01);
    model_inst.set(9'h004);
    model_inst.set(9'h000);
    for (int i = 0; i < 6; i++) begin
      tk(s);
      chk(s, int'(i == 5), "delayed strobe");
    end
    chk(smp, 1'b0, "delayed value");
    done("sample time");
    tally_and_finish();
  end
endmodule // tb_itc_top

`default_nettype wire
